// file: inc/icm_pkg.sv
// Constants and types of the ISA configuration mode controller
package icm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_ADDR_PORT = 4'h0;
  localparam logic [3:0] REG_WAKE = 4'h1;
  localparam logic [3:0] REG_SET_CSN = 4'h2;
  localparam logic [3:0] REG_CMD = 4'h3;
  localparam logic [3:0] REG_LD_IO = 4'h4;
  localparam logic [3:0] REG_LD_MEM = 4'h5;
  localparam logic [3:0] REG_LD_IRQ = 4'h6;
  localparam logic [3:0] REG_LEG_A = 4'h8;
  localparam logic [3:0] REG_LEG_B = 4'h9;
  localparam logic [3:0] REG_LEG_C = 4'hA;
  localparam logic [3:0] REG_STATUS = 4'hB;
  localparam logic [3:0] REG_CSN = 4'hC;
  localparam logic [3:0] REG_OPMODE = 4'hD;
  localparam int CMD_WAIT_KEY_BIT = 0;
  localparam int CMD_RESET_CSN_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // Legacy register C layout and stored configuration
  // ---------------------------------------------------------------
  localparam int IRQ_LSB = 0;
  localparam int IRQ_W = 4;
  localparam int ROM_LSB = 4;
  localparam int ROM_W = 2;
  localparam logic [7:0] OPMODE_JUMPERLESS = 8'h4A;
  localparam logic [7:0] OPMODE_PNP = 8'h50;
  localparam logic [5:0] EE_WORD_AB = 6'h0E;
  localparam logic [5:0] EE_WORD_C = 6'h0F;

  // ---------------------------------------------------------------
  // Initiation keys
  // ---------------------------------------------------------------
  localparam int KEY_LEN = 32;
  localparam logic [7:0] PNP_KEY_SEED = 8'h6A;
  localparam logic [7:0] VENDOR_KEY_SEED = 8'h3C;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0]
  {
    ST_WAIT_KEY = 4'h1,
    ST_SLEEP = 4'h2,
    ST_ISOL = 4'h4,
    ST_CONFIG = 4'h8
  } icm_state_t;

  typedef enum logic [2:0]
  {
    MODE_JUMPERLESS = 3'h1,
    MODE_PNP = 3'h2,
    MODE_AUTO = 3'h4
  } icm_mode_t;

endpackage

// file: logic/icm_key_match.sv
// Initiation key matcher: follows a 32-write LFSR sequence
`timescale 1ns/1ns
`default_nettype none
module icm_key_match
#(
  parameter logic [7:0] SEED = 8'h6A,
  parameter int LEN = 32,
  parameter int CNT_W = 6
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Address port writes
  input wire logic en_i,
  input wire logic wr_i,
  input wire logic [7:0] data_i,
  // Key seen, one cycle
  output logic hit_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [7:0] exp_q;
  logic hit_q;

  // Next key byte: shift right, feed back bit0 xor bit1
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    lfsr_next = {x[0] ^ x[1], x[7:1]};
  endfunction

  // Any wrong byte restarts from the seed; no half-matched key survives
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      exp_q <= SEED;
      hit_q <= 1'b0;
    end
    else if (ce_i)
    begin
      hit_q <= 1'b0;
      if (!en_i)
      begin
        cnt_q <= '0;
        exp_q <= SEED;
      end
      else if (wr_i && data_i == exp_q)
      begin
        if (cnt_q == CNT_W'(LEN - 1))
        begin
          hit_q <= 1'b1;
          cnt_q <= '0;
          exp_q <= SEED;
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
          exp_q <= lfsr_next(exp_q);
        end
      end
      else if (wr_i)
      begin
        cnt_q <= '0;
        exp_q <= SEED;
      end
    end
  end

  assign hit_o = hit_q;

  a_key_hit_enabled: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    $rose(hit_o) |-> $past(en_i && wr_i && ce_i))
    else $error("key hit without an enabled write");

endmodule
`default_nettype wire

// file: logic/icm_ee_loader.sv
// Captures configuration words from the serial EEPROM word stream
`timescale 1ns/1ns
`default_nettype none
module icm_ee_loader
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // EEPROM word stream
  input wire logic ee_valid_i,
  input wire logic [5:0] ee_addr_i,
  input wire logic [15:0] ee_data_i,
  input wire logic ee_last_i,
  // Captured configuration
  output logic [7:0] cfg_a_o,
  output logic [7:0] cfg_b_o,
  output logic [7:0] cfg_c_o,
  output logic [7:0] opmode_o,
  output logic done_o
);

  // Words 0E and 0F carry the legacy settings and the mode byte
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cfg_a_o <= icm_pkg::RESET_BYTE;
      cfg_b_o <= icm_pkg::RESET_BYTE;
      cfg_c_o <= icm_pkg::RESET_BYTE;
      opmode_o <= icm_pkg::RESET_BYTE;
      done_o <= 1'b0;
    end
    else if (ce_i && ee_valid_i && !done_o)
    begin
      if (ee_addr_i == icm_pkg::EE_WORD_AB)
      begin
        cfg_a_o <= ee_data_i[7:0];
        cfg_b_o <= ee_data_i[15:8];
      end
      if (ee_addr_i == icm_pkg::EE_WORD_C)
      begin
        cfg_c_o <= ee_data_i[7:0];
        opmode_o <= ee_data_i[15:8];
      end
      done_o <= ee_last_i;
    end
  end

  a_load_done_hold: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    done_o |=> done_o)
    else $error("load done dropped without reset");

endmodule
`default_nettype wire

// file: logic/icm_config_mode.sv
// ISA Plug and Play configuration mode controller, top level
`timescale 1ns/1ns
`default_nettype none
module icm_config_mode
(
  // Clock, hardware reset and enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [icm_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [icm_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [icm_pkg::DATA_W-1:0] reg_rdata_o,
  // EEPROM word stream
  input wire logic ee_valid_i,
  input wire logic [5:0] ee_addr_i,
  input wire logic [15:0] ee_data_i,
  input wire logic ee_last_i,
  // Active resource settings
  output logic [7:0] cfg_io_base_o,
  output logic [7:0] cfg_mem_base_o,
  output logic [3:0] cfg_irq_o,
  output logic [1:0] boot_rom_size_o,
  // Mode and state
  output logic [2:0] op_mode_o,
  output logic [3:0] pnp_state_o,
  output logic load_done_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  icm_pkg::icm_state_t state_q;
  icm_pkg::icm_mode_t mode_q;
  logic [7:0] csn_q;
  logic [7:0] ld_io_q;
  logic [7:0] ld_mem_q;
  logic [3:0] ld_irq_q;
  logic [7:0] leg_a_q;
  logic [7:0] leg_b_q;
  logic [7:0] leg_c_q;
  logic [7:0] rdata_q;
  logic applied_q;
  logic [7:0] ee_a;
  logic [7:0] ee_b;
  logic [7:0] ee_c;
  logic [7:0] ee_opmode;
  logic ee_done;
  logic apply;
  logic wr;
  logic in_config;
  logic port_wr;
  logic ven_hit;
  logic pnp_hit;
  logic pnp_key_en;
  logic wake_wr;
  logic csn_wr;
  logic cmd_wr;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Write strobes per register; every write counts only with ce high
  assign wr = ce_i && reg_we_i;
  assign port_wr = wr && reg_addr_i == icm_pkg::REG_ADDR_PORT;
  assign wake_wr = wr && reg_addr_i == icm_pkg::REG_WAKE;
  assign csn_wr = wr && reg_addr_i == icm_pkg::REG_SET_CSN;
  assign cmd_wr = wr && reg_addr_i == icm_pkg::REG_CMD;
  assign in_config = state_q == icm_pkg::ST_CONFIG;
  // Defaults are applied once, in the cycle after the last word is taken
  assign apply = ce_i && ee_done && !applied_q;

  // ---------------------------------------------------------------
  // EEPROM defaults
  // ---------------------------------------------------------------
  icm_ee_loader u_loader
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .ee_valid_i(ee_valid_i),
    .ee_addr_i(ee_addr_i),
    .ee_data_i(ee_data_i),
    .ee_last_i(ee_last_i),
    .cfg_a_o(ee_a),
    .cfg_b_o(ee_b),
    .cfg_c_o(ee_c),
    .opmode_o(ee_opmode),
    .done_o(ee_done)
  );

  // Load-done flag; the reset reloads everything from the stream
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      applied_q <= 1'b0;
    else if (apply)
      applied_q <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Operation mode
  // ---------------------------------------------------------------
  // Starts jumperless; the stored byte is looked at once per reset only
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      mode_q <= icm_pkg::MODE_JUMPERLESS;
    else if (apply)
    begin
      if (ee_opmode == icm_pkg::OPMODE_JUMPERLESS)
        mode_q <= icm_pkg::MODE_JUMPERLESS;
      else if (ee_opmode == icm_pkg::OPMODE_PNP)
        mode_q <= icm_pkg::MODE_PNP;
      else
        mode_q <= icm_pkg::MODE_AUTO;
    end
  end

  // ---------------------------------------------------------------
  // Initiation keys
  // ---------------------------------------------------------------
  // Auto mode must see the standard key to detect a PnP environment
  assign pnp_key_en = applied_q && mode_q != icm_pkg::MODE_JUMPERLESS;

  icm_key_match #(
    .SEED(icm_pkg::VENDOR_KEY_SEED),
    .LEN(icm_pkg::KEY_LEN)
  ) u_vendor_key (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .en_i(applied_q),
    .wr_i(port_wr),
    .data_i(reg_wdata_i),
    .hit_o(ven_hit)
  );

  icm_key_match #(
    .SEED(icm_pkg::PNP_KEY_SEED),
    .LEN(icm_pkg::KEY_LEN)
  ) u_pnp_key (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .en_i(pnp_key_en),
    .wr_i(port_wr),
    .data_i(reg_wdata_i),
    .hit_o(pnp_hit)
  );

  // ---------------------------------------------------------------
  // Plug and Play state machine
  // ---------------------------------------------------------------
  // Either key moves Wait for Key to Sleep, the standard key only outside jumperless mode; a vendor key does so in any mode
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state_q <= icm_pkg::ST_WAIT_KEY;
    else if (ce_i)
    begin
      if (cmd_wr && reg_wdata_i[icm_pkg::CMD_WAIT_KEY_BIT])
        state_q <= icm_pkg::ST_WAIT_KEY;
      else
      begin
        unique case (state_q)
          icm_pkg::ST_WAIT_KEY:
            if (ven_hit || pnp_hit)
              state_q <= icm_pkg::ST_SLEEP;
          icm_pkg::ST_SLEEP:
            if (wake_wr && reg_wdata_i == csn_q)
              state_q <= (csn_q == 8'h00) ? icm_pkg::ST_ISOL
                                          : icm_pkg::ST_CONFIG;
          icm_pkg::ST_ISOL:
            if (csn_wr)
              state_q <= icm_pkg::ST_CONFIG;
            else if (wake_wr && reg_wdata_i != csn_q)
              state_q <= icm_pkg::ST_SLEEP;
          icm_pkg::ST_CONFIG:
            if (wake_wr && reg_wdata_i != csn_q)
              state_q <= icm_pkg::ST_SLEEP;
        endcase
      end
    end
  end

  // Card select number; the reset command zeroes it but keeps the state
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      csn_q <= 8'h00;
    else if (cmd_wr && reg_wdata_i[icm_pkg::CMD_RESET_CSN_BIT])
      csn_q <= 8'h00;
    else if (csn_wr && state_q == icm_pkg::ST_ISOL)
      csn_q <= reg_wdata_i;
  end

  // ---------------------------------------------------------------
  // Resource registers
  // ---------------------------------------------------------------
  // Logical-device copy: defaults at load, software writes in Config
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ld_io_q <= icm_pkg::RESET_BYTE;
      ld_mem_q <= icm_pkg::RESET_BYTE;
      ld_irq_q <= '0;
    end
    else if (apply)
    begin
      ld_io_q <= ee_a;
      ld_mem_q <= ee_b;
      ld_irq_q <= ee_c[icm_pkg::IRQ_LSB +: icm_pkg::IRQ_W];
    end
    else if (wr && in_config)
    begin
      if (reg_addr_i == icm_pkg::REG_LD_IO)
        ld_io_q <= reg_wdata_i;
      if (reg_addr_i == icm_pkg::REG_LD_MEM)
        ld_mem_q <= reg_wdata_i;
      if (reg_addr_i == icm_pkg::REG_LD_IRQ)
        ld_irq_q <= reg_wdata_i[icm_pkg::IRQ_LSB +: icm_pkg::IRQ_W];
    end
  end

  // Legacy copy follows every write; the ROM size bits never take one
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      leg_a_q <= icm_pkg::RESET_BYTE;
      leg_b_q <= icm_pkg::RESET_BYTE;
      leg_c_q <= icm_pkg::RESET_BYTE;
    end
    else if (apply)
    begin
      leg_a_q <= ee_a;
      leg_b_q <= ee_b;
      leg_c_q <= ee_c;
    end
    else if (wr && in_config)
    begin
      if (reg_addr_i == icm_pkg::REG_LD_IO)
        leg_a_q <= reg_wdata_i;
      if (reg_addr_i == icm_pkg::REG_LD_MEM)
        leg_b_q <= reg_wdata_i;
      if (reg_addr_i == icm_pkg::REG_LD_IRQ)
        leg_c_q[icm_pkg::IRQ_LSB +: icm_pkg::IRQ_W] <=
          reg_wdata_i[icm_pkg::IRQ_LSB +: icm_pkg::IRQ_W];
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Data stand one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_q <= icm_pkg::RESET_BYTE;
    else if (ce_i && reg_re_i)
    begin
      unique case (reg_addr_i)
        icm_pkg::REG_LD_IO: rdata_q <= ld_io_q;
        icm_pkg::REG_LD_MEM: rdata_q <= ld_mem_q;
        icm_pkg::REG_LD_IRQ: rdata_q <= {4'h0, ld_irq_q};
        icm_pkg::REG_LEG_A: rdata_q <= leg_a_q;
        icm_pkg::REG_LEG_B: rdata_q <= leg_b_q;
        icm_pkg::REG_LEG_C: rdata_q <= leg_c_q;
        icm_pkg::REG_STATUS: rdata_q <= {applied_q, mode_q, state_q};
        icm_pkg::REG_CSN: rdata_q <= csn_q;
        icm_pkg::REG_OPMODE: rdata_q <= ee_opmode;
        default: rdata_q <= icm_pkg::RESET_BYTE;
      endcase
    end
  end

  // All outputs are flops already
  assign reg_rdata_o = rdata_q;
  assign cfg_io_base_o = ld_io_q;
  assign cfg_mem_base_o = ld_mem_q;
  assign cfg_irq_o = ld_irq_q;
  assign boot_rom_size_o = leg_c_q[icm_pkg::ROM_LSB +: icm_pkg::ROM_W];
  assign op_mode_o = mode_q;
  assign pnp_state_o = state_q;
  assign load_done_o = applied_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_cfg_io_wr;
    ce_i && reg_we_i && in_config && reg_addr_i == icm_pkg::REG_LD_IO
      && !apply;
  endsequence

  sequence s_vendor_wake;
    ce_i && ven_hit && state_q == icm_pkg::ST_WAIT_KEY && !cmd_wr;
  endsequence

  a_reset_wait_key: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    $rose(rst_n_i) |-> state_q == icm_pkg::ST_WAIT_KEY && csn_q == 8'h00
      && !applied_q)
    else $error("reset did not reach wait for key with csn zero");

  a_mode_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    applied_q |=> $stable(mode_q))
    else $error("mode changed without hardware reset");

  a_mode_decode: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    apply |=> (mode_q == icm_pkg::MODE_PNP)
      == ($past(ee_opmode) == icm_pkg::OPMODE_PNP)
      && (mode_q == icm_pkg::MODE_JUMPERLESS)
      == ($past(ee_opmode) == icm_pkg::OPMODE_JUMPERLESS))
    else $error("mode byte decoded wrongly");

  a_std_key_blocked: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    mode_q == icm_pkg::MODE_JUMPERLESS && $stable(mode_q) |-> !pnp_hit)
    else $error("standard key honoured in jumperless mode");

  a_key_after_load: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (ven_hit || pnp_hit) |-> applied_q)
    else $error("key recognised before defaults loaded");

  a_vendor_opens: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    s_vendor_wake |=> state_q == icm_pkg::ST_SLEEP)
    else $error("vendor key did not leave wait for key");

  a_write_mirror: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    s_cfg_io_wr |=> leg_a_q == $past(reg_wdata_i)
      && ld_io_q == leg_a_q)
    else $error("logical device write not mirrored");

  a_rom_size_fixed: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    !apply |=> $stable(boot_rom_size_o))
    else $error("boot rom size changed outside load");

  a_defaults_load: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    apply |=> ld_io_q == $past(ee_a) && leg_c_q == $past(ee_c)
      && applied_q)
    else $error("eeprom defaults not applied");

endmodule
`default_nettype wire

// file: bench/icm_ee_src.sv
// Serial EEPROM word source that feeds the configuration stream
`timescale 1ns/1ns
`default_nettype none
module icm_ee_src
(
  // Clock
  input wire logic clk_i,
  // Word stream towards the device
  output logic ee_valid_o,
  output logic [5:0] ee_addr_o,
  output logic [15:0] ee_data_o,
  output logic ee_last_o
);
  // Quiet lines until the first word
  initial
  begin
    ee_valid_o = 1'b0;
    ee_addr_o = 6'h00;
    ee_data_o = 16'h0000;
    ee_last_o = 1'b0;
  end

  // One word, then a gap; idle lines carry the inverse so stale data fails
  task automatic word(input logic [5:0] a, input logic [15:0] d,
    input logic last, input int gap);
    ee_valid_o <= 1'b1;
    ee_addr_o <= a;
    ee_data_o <= d;
    ee_last_o <= last;
    @(posedge clk_i);
    ee_valid_o <= 1'b0;
    ee_last_o <= 1'b0;
    ee_addr_o <= ~a;
    ee_data_o <= ~d;
    repeat (gap + 1) @(posedge clk_i);
  endtask

  // Image holds whatever the host last programmed; order may be swapped
  task automatic send(input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] c, input logic [7:0] m, input int gap, input bit swap);
    word(6'h07, 16'h1234, 1'b0, gap);
    word(swap ? icm_pkg::EE_WORD_C : icm_pkg::EE_WORD_AB,
      swap ? {m, c} : {b, a}, 1'b0, gap);
    word(swap ? icm_pkg::EE_WORD_AB : icm_pkg::EE_WORD_C,
      swap ? {b, a} : {m, c}, 1'b1, gap);
  endtask
endmodule
`default_nettype wire

// file: bench/test_icm_config_mode.sv
// Self-checking bench for the configuration mode controller
`timescale 1ns/1ns
`default_nettype none
module test_icm_config_mode;
  logic clk_i = 1'b0;
  logic rst_n_i, ce_i, reg_we_i, reg_re_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic ee_valid_i, ee_last_i;
  logic [5:0] ee_addr_i;
  logic [15:0] ee_data_i;
  logic [7:0] cfg_io_base_o, cfg_mem_base_o;
  logic [3:0] cfg_irq_o, pnp_state_o;
  logic [1:0] boot_rom_size_o;
  logic [2:0] op_mode_o;
  logic load_done_o;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'hC40A;
  logic [7:0] exp_q[$];
  string name_q[$];
  logic rd_pend = 1'b0;
  logic [7:0] def_a, def_b, def_c, d;
  logic [7:0] modes [3] = '{8'h4A, 8'h50, 8'h77};
  logic [2:0] mcode [3] = '{3'h1, 3'h2, 3'h4};

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  icm_config_mode icm_config_mode_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .ee_valid_i(ee_valid_i), .ee_addr_i(ee_addr_i), .ee_data_i(ee_data_i),
    .ee_last_i(ee_last_i), .cfg_io_base_o(cfg_io_base_o),
    .cfg_mem_base_o(cfg_mem_base_o), .cfg_irq_o(cfg_irq_o),
    .boot_rom_size_o(boot_rom_size_o), .op_mode_o(op_mode_o),
    .pnp_state_o(pnp_state_o), .load_done_o(load_done_o));

  icm_ee_src icm_ee_src_inst (.clk_i(clk_i), .ee_valid_o(ee_valid_i),
    .ee_addr_o(ee_addr_i), .ee_data_o(ee_data_i), .ee_last_o(ee_last_i));

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read data stand from the cycle after the strobe until the next read; a hang ends the run
  always @(posedge clk_i)
  begin
    rd_pend <= reg_re_i & ce_i;
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      end_of_test();
    end
  end

  // Oldest note is matched against the answer while it is settled
  always @(negedge clk_i)
    if (rd_pend)
      chk(name_q.pop_front(), exp_q.pop_front(), reg_rdata_o);

  // Bus cycles leave one idle edge so no strobe is assigned twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic send_key(input logic [7:0] seed_b);
    logic [7:0] b;
    b = seed_b;
    repeat (icm_pkg::KEY_LEN)
    begin
      wr(icm_pkg::REG_ADDR_PORT, b);
      b = {b[0] ^ b[1], b[7:1]};
    end
    repeat (2) @(posedge clk_i);
  endtask

  task automatic hw_reset();
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask

  // Stream the image with a random pace and order, then wait for apply
  task automatic load(input logic [7:0] m);
    int n;
    icm_ee_src_inst.send(def_a, def_b, def_c, m,
      $unsigned($random(seed)) % 4, 1'($random(seed)));
    n = 0;
    while (load_done_o !== 1'b1 && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    chk("load_done", 8'h01, {7'h00, load_done_o});
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    def_a = 8'($random(seed));
    def_b = 8'($random(seed));
    def_c = {2'b00, 6'($random(seed))};
    // Each stored mode byte in turn; later passes reset out of Config
    for (int i = 0; i < 3; i++)
    begin
      hw_reset();
      rd(icm_pkg::REG_STATUS, 8'h11, "status after reset");
      rd(icm_pkg::REG_CSN, 8'h00, "csn after reset");
      chk("io after reset", 8'h00, cfg_io_base_o);
      send_key(icm_pkg::VENDOR_KEY_SEED);
      rd(icm_pkg::REG_STATUS, 8'h11, "key before load");
      load(modes[i]);
      chk("io default", def_a, cfg_io_base_o);
      chk("mem default", def_b, cfg_mem_base_o);
      chk("irq default", {4'h0, def_c[3:0]}, {4'h0, cfg_irq_o});
      chk("rom size", {6'h00, def_c[5:4]}, {6'h00, boot_rom_size_o});
      rd(icm_pkg::REG_LEG_A, def_a, "legacy a");
      rd(icm_pkg::REG_LEG_C, def_c, "legacy c");
      rd(icm_pkg::REG_OPMODE, modes[i], "mode byte");
      send_key(icm_pkg::PNP_KEY_SEED);
      rd(icm_pkg::REG_STATUS, {1'b1, mcode[i], (i == 0) ? 4'h1 : 4'h2},
        "standard key");
      wr(icm_pkg::REG_CMD, 8'h01);
      rd(icm_pkg::REG_STATUS, {1'b1, mcode[i], 4'h1}, "wait command");
      send_key(icm_pkg::VENDOR_KEY_SEED);
      rd(icm_pkg::REG_STATUS, {1'b1, mcode[i], 4'h2}, "vendor key");
      wr(icm_pkg::REG_WAKE, 8'h00);
      rd(icm_pkg::REG_STATUS, {1'b1, mcode[i], 4'h4}, "isolation");
      wr(icm_pkg::REG_SET_CSN, 8'h05);
      rd(icm_pkg::REG_STATUS, {1'b1, mcode[i], 4'h8}, "config");
      rd(icm_pkg::REG_CSN, 8'h05, "csn set");
      chk("state out", 8'h08, {4'h0, pnp_state_o});
      chk("mode out", {5'h00, mcode[i]}, {5'h00, op_mode_o});
      d = 8'($random(seed));
      wr(icm_pkg::REG_LD_IO, d);
      chk("io written", d, cfg_io_base_o);
      rd(icm_pkg::REG_LD_IO, d, "ld io readback");
      rd(icm_pkg::REG_LEG_A, d, "legacy a copy");
      // A write while the clock enable is low must leave the registers alone
      ce_i <= 1'b0;
      wr(icm_pkg::REG_LD_IO, ~d);
      ce_i <= 1'b1;
      chk("io frozen", d, cfg_io_base_o);
      wr(icm_pkg::REG_LD_MEM, ~d);
      chk("mem written", ~d, cfg_mem_base_o);
      rd(icm_pkg::REG_LEG_B, ~d, "legacy b copy");
      wr(icm_pkg::REG_LD_IRQ, 8'hF0 | d);
      chk("irq written", {4'h0, d[3:0]}, {4'h0, cfg_irq_o});
      rd(icm_pkg::REG_LEG_C, {2'b00, def_c[5:4], d[3:0]},
        "legacy c copy");
      chk("rom size kept", {6'h00, def_c[5:4]},
        {6'h00, boot_rom_size_o});
      rd(4'h7, 8'h00, "unmapped");
      // A second stream and a write to the mode byte must change nothing
      icm_ee_src_inst.send(8'h00, 8'h00, 8'h00, modes[(i + 1) % 3],
        0, 1'b0);
      wr(icm_pkg::REG_OPMODE, 8'h50);
      rd(icm_pkg::REG_STATUS, {1'b1, mcode[i], 4'h8},
        "mode held");
      chk("io kept", d, cfg_io_base_o);
      $display("mode pass %0d done", i);
    end
    hw_reset();
    rd(icm_pkg::REG_STATUS, 8'h11, "reset from config");
    rd(icm_pkg::REG_CSN, 8'h00, "csn cleared");
    $display("final reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
